// [abcd_pkg.sv]
// Package of encodings, widths and phase codes for the AND and bit-clear decoder
`default_nettype none
package abcd_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int DATA_W = 8;
    localparam int INSN_W = 16;
    localparam int ADDR_W = 8;
    localparam int BITPOS_W = 3;

    // ****************************************
    // Instruction fields
    // ****************************************
    localparam int AND_OP_MSB = 15;
    localparam int AND_OP_LSB = 9;
    localparam logic [6:0] AND_OPCODE = 7'h05;
    localparam int AND_DEST_BIT = 8;
    localparam int CLR_OP_MSB = 15;
    localparam int CLR_OP_LSB = 11;
    localparam logic [4:0] CLR_OPCODE = 5'h11;
    localparam int CLR_POS_MSB = 10;
    localparam int CLR_POS_LSB = 8;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;

    // ****************************************
    // Phases of one instruction cycle
    // ****************************************
    typedef enum logic [3:0] {
        PH_DECODE = 4'h1,
        PH_READ = 4'h2,
        PH_EXEC = 4'h4,
        PH_WRITE = 4'h8
    } abcd_phase_t;
endpackage
`default_nettype wire

// [abcd_alu.sv]
// Combinational execute unit for the AND and bit-clear operations
`timescale 1ns/1ps
`default_nettype none
module abcd_alu (
    input wire logic [7:0] opa,
    input wire logic [7:0] opb,
    input wire logic [2:0] bit_pos,
    input wire logic sel_clear,
    output logic [7:0] result,
    output logic is_zero
);
    always_comb begin
        if (sel_clear) begin
            result = opb & ~(8'h01 << bit_pos); // RL3
        end else begin
            result = opa & opb; // RL1
        end
        is_zero = (result == 8'h00);
    end
endmodule
`default_nettype wire

// [abcd_core.sv]
// Four-phase decode and execute of the AND-with-file and bit-clear words
//
// Behaviour
// RL1: and_working_with_file ANDs W with f into W (d=0) or f (d=1); Z only.
// RL2: and_working_with_file is top bits 0000101, then d, then 8-bit f.
// RL3: single_bit_clear forces bit b of f to zero, keeps the rest, no flag.
// RL4: single_bit_clear is top bits 10001, then 3-bit b, then 8-bit f.
// RL5: One word, one cycle of four phases: decode, read, execute, write.
`timescale 1ns/1ps
`default_nettype none
module abcd_core (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic INSN_VALID,
    input wire logic [15:0] INSN,
    output logic INSN_READY,
    output logic [7:0] FILE_ADDR,
    output logic FILE_RD,
    input wire logic [7:0] FILE_RDATA,
    output logic FILE_WR,
    output logic [7:0] FILE_WDATA,
    output logic [7:0] WORKING_REGISTER,
    output logic ZERO_FLAG,
    output logic ILLEGAL,
    output logic DONE
);
    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic is_and(input logic [15:0] w);
        return w[abcd_pkg::AND_OP_MSB:abcd_pkg::AND_OP_LSB]
            == abcd_pkg::AND_OPCODE; // RL2
    endfunction

    function automatic logic is_clr(input logic [15:0] w);
        return w[abcd_pkg::CLR_OP_MSB:abcd_pkg::CLR_OP_LSB]
            == abcd_pkg::CLR_OPCODE; // RL4
    endfunction

    function automatic logic is_legal(input logic [15:0] w);
        return is_and(w) || is_clr(w);
    endfunction

    abcd_pkg::abcd_phase_t phase_q;
    logic [15:0] insn_q;
    logic op_and_q;
    logic op_clr_q;
    logic [7:0] opnd_q;
    logic [7:0] res_q;
    logic zero_q;
    logic [7:0] alu_res;
    logic alu_zero;
    logic dest_file;
    logic take_word;
    logic word_legal;
    logic [7:0] word_addr;
    logic [2:0] held_pos;

    assign INSN_READY = (phase_q == abcd_pkg::PH_DECODE);

    // ****************************************
    // Word fields
    // ****************************************
    // A word is taken only while ready, so a word offered in a busy phase
    // waits at the port instead of being lost
    assign take_word = INSN_READY && INSN_VALID;
    assign word_legal = is_legal(INSN);
    assign word_addr = INSN[abcd_pkg::ADDR_MSB:abcd_pkg::ADDR_LSB];
    assign held_pos = insn_q[abcd_pkg::CLR_POS_MSB:abcd_pkg::CLR_POS_LSB];
    // The bit-clear word reuses bit 8 as the low position bit, so the
    // destination select only counts for the AND
    assign dest_file = op_clr_q | insn_q[abcd_pkg::AND_DEST_BIT];

    // ****************************************
    // Phase sequencer
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            phase_q <= abcd_pkg::PH_DECODE;
        end else begin
            // An illegal word leaves the sequencer in decode, so the next
            // word may be offered on the very next clock
            case (phase_q) // RL5
                abcd_pkg::PH_DECODE: begin
                    if (take_word && word_legal) begin
                        phase_q <= abcd_pkg::PH_READ;
                    end
                end
                // Read, execute and write each take one clock
                abcd_pkg::PH_READ: phase_q <= abcd_pkg::PH_EXEC;
                abcd_pkg::PH_EXEC: phase_q <= abcd_pkg::PH_WRITE;
                abcd_pkg::PH_WRITE: phase_q <= abcd_pkg::PH_DECODE;
                default: phase_q <= abcd_pkg::PH_DECODE;
            endcase
        end
    end

    // ****************************************
    // Decode latch
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            insn_q <= 16'h0000;
            op_and_q <= 1'b0;
            op_clr_q <= 1'b0;
        end else begin
            // Latched on every word taken while ready; only a legal one starts phases
            if (take_word) begin
                insn_q <= INSN;
                op_and_q <= is_and(INSN); // RL2
                op_clr_q <= is_clr(INSN); // RL4
            end
        end
    end

    // ****************************************
    // Illegal word flag
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ILLEGAL <= 1'b0;
        end else begin
            ILLEGAL <= take_word && !word_legal; // RL2 RL4
        end
    end

    // ****************************************
    // File access
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            FILE_ADDR <= 8'h00;
            FILE_RD <= 1'b0;
        end else begin
            FILE_RD <= 1'b0;
            // The address stays put after the read, so the write phase
            // reuses it
            if (take_word && word_legal) begin
                FILE_ADDR <= word_addr;
                FILE_RD <= 1'b1; // RL5
            end
        end
    end

    // Read data is taken at the end of the read phase, while FILE_RD is
    // high; the file side must answer within that same cycle
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            opnd_q <= 8'h00;
        end else if (phase_q == abcd_pkg::PH_READ) begin
            opnd_q <= FILE_RDATA;
        end
    end

    // One ALU serves both words, steered by the latched opcode
    abcd_alu abcd_alu_inst (
        .opa(WORKING_REGISTER),
        .opb(opnd_q),
        .bit_pos(held_pos),
        .sel_clear(op_clr_q),
        .result(alu_res),
        .is_zero(alu_zero)
    );

    // ****************************************
    // Execute
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            res_q <= 8'h00;
            zero_q <= 1'b0;
        end else if (phase_q == abcd_pkg::PH_EXEC) begin
            // The working register is used as it stands in the execute phase
            res_q <= alu_res;
            zero_q <= alu_zero;
        end
    end

    // ****************************************
    // Write back
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            FILE_WR <= 1'b0;
            FILE_WDATA <= 8'h00;
        end else begin
            FILE_WR <= 1'b0;
            if (phase_q == abcd_pkg::PH_WRITE && dest_file) begin
                FILE_WR <= 1'b1; // RL1
                FILE_WDATA <= res_q; // RL3
            end
        end
    end

    // Every legal word ends with one DONE pulse, whatever its destination
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            DONE <= 1'b0;
        end else begin
            DONE <= (phase_q == abcd_pkg::PH_WRITE); // RL5
        end
    end

    // Only an AND with d=0 lands in the working register
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            WORKING_REGISTER <= abcd_pkg::WORK_RESET;
        end else if (phase_q == abcd_pkg::PH_WRITE && op_and_q
                     && !dest_file) begin
            WORKING_REGISTER <= res_q; // RL1
        end
    end

    // Only the AND touches the zero flag
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ZERO_FLAG <= abcd_pkg::ZERO_RESET;
        end else if (phase_q == abcd_pkg::PH_WRITE && op_and_q) begin
            ZERO_FLAG <= zero_q; // RL1
        end
    end
endmodule
`default_nettype wire

// [abcd_file_model.sv]
// Behavioural file register array facing the decoder
`timescale 1ns/1ps
`default_nettype none
module abcd_file_model (
    input wire logic CLK,
    input wire logic [7:0] FILE_ADDR,
    input wire logic FILE_RD,
    input wire logic FILE_WR,
    input wire logic [7:0] FILE_WDATA,
    output logic [7:0] FILE_RDATA
);
    logic [7:0] mem [256];
    // Data answers within the cycle of the read; outside it the bus shows
    // the inverse, so a sample taken in the wrong cycle is caught
    assign FILE_RDATA = FILE_RD ? mem[FILE_ADDR] : ~mem[FILE_ADDR];
    always @(posedge CLK) begin
        if (FILE_WR) begin
            mem[FILE_ADDR] <= FILE_WDATA;
        end
    end
endmodule
`default_nettype wire

// [abcd_properties.sv]
// Port checks of the AND and bit-clear decoder
`timescale 1ns/1ps
`default_nettype none
module abcd_checker (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic INSN_VALID,
    input wire logic [15:0] INSN,
    input wire logic INSN_READY,
    input wire logic [7:0] FILE_ADDR,
    input wire logic FILE_RD,
    input wire logic [7:0] FILE_RDATA,
    input wire logic FILE_WR,
    input wire logic [7:0] FILE_WDATA,
    input wire logic [7:0] WORKING_REGISTER,
    input wire logic ZERO_FLAG,
    input wire logic ILLEGAL,
    input wire logic DONE
);
    logic is_and;
    logic is_clr;
    assign is_and = INSN[15:9] == abcd_pkg::AND_OPCODE;
    assign is_clr = INSN[15:11] == abcd_pkg::CLR_OPCODE;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence s_go;
        INSN_READY && INSN_VALID && (is_and || is_clr);
    endsequence
    sequence s_bad;
        INSN_READY && INSN_VALID && !(is_and || is_clr);
    endsequence
    sequence s_and(logic d);
        s_go ##0 (is_and && INSN[8] == d);
    endsequence
    a_read_request: assert property (s_go |=>
        FILE_RD && FILE_ADDR == $past(INSN[7:0])) else $error("bad read");
    a_busy_phases: assert property (s_go |=>
        !INSN_READY [*3] ##1 (INSN_READY && DONE)) else $error("bad phases");
    a_and_to_file: assert property (s_and(1'b1) |-> ##4 FILE_WR &&
        FILE_WDATA == ($past(WORKING_REGISTER) & $past(FILE_RDATA, 3)) &&
        ZERO_FLAG == (FILE_WDATA == 8'h00)) else $error("bad and to f");
    a_and_to_work: assert property (s_and(1'b0) |-> ##4 !FILE_WR &&
        WORKING_REGISTER == ($past(WORKING_REGISTER) & $past(FILE_RDATA, 3))
        && ZERO_FLAG == (WORKING_REGISTER == 8'h00)) else $error("bad and");
    a_clear_bit: assert property (s_go ##0 is_clr |-> ##4 FILE_WR &&
        FILE_WDATA == ($past(FILE_RDATA, 3)
        & ~(8'h01 << $past(INSN[10:8], 4))) && $stable(ZERO_FLAG)
        && $stable(WORKING_REGISTER)) else $error("bad clr");
    a_illegal_dropped: assert property (s_bad |=> ILLEGAL && INSN_READY
        && !FILE_RD) else $error("bad illegal");
    a_write_at_done: assert property (FILE_WR |-> DONE)
        else $error("write outside done");
endmodule
bind abcd_core abcd_checker abcd_checker_inst (.CLK(CLK), .NRST(NRST),
    .INSN_VALID(INSN_VALID), .INSN(INSN), .INSN_READY(INSN_READY),
    .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_RDATA(FILE_RDATA),
    .FILE_WR(FILE_WR), .FILE_WDATA(FILE_WDATA), .DONE(DONE),
    .WORKING_REGISTER(WORKING_REGISTER), .ZERO_FLAG(ZERO_FLAG),
    .ILLEGAL(ILLEGAL));
`default_nettype wire

// [and_and_bit_clear_decode_tb.sv]
// Self-checking bench for the AND and bit-clear decoder
`timescale 1ns/1ps
`default_nettype none
module and_and_bit_clear_decode_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic vld = 1'b0;
    logic [15:0] insn = 16'h0000;
    logic rdy, frd, fwr, zf, ill, done;
    logic [7:0] fa, frdata, fwd, wr;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    abcd_core abcd_core_inst (.CLK(clk), .NRST(nrst), .INSN_VALID(vld),
        .INSN(insn), .INSN_READY(rdy), .FILE_ADDR(fa), .FILE_RD(frd),
        .FILE_RDATA(frdata), .FILE_WR(fwr), .FILE_WDATA(fwd),
        .WORKING_REGISTER(wr), .ZERO_FLAG(zf), .ILLEGAL(ill), .DONE(done));
    abcd_file_model abcd_file_model_inst (.CLK(clk), .FILE_ADDR(fa),
        .FILE_RD(frd), .FILE_WR(fwr), .FILE_WDATA(fwd), .FILE_RDATA(frdata));
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic run_op(logic [15:0] w, logic bad);
        int n = 0;
        @(posedge clk);
        vld <= 1'b1;
        insn <= w;
        @(posedge clk);
        vld <= 1'b0;
        insn <= ~w;
        #1;
        chk("illegal", {7'h00, ill}, {7'h00, bad});
        chk("read", {7'h00, frd}, {7'h00, !bad});
        chk("busy", {7'h00, rdy}, {7'h00, bad});
        if (!bad) begin
            while (done !== 1'b1 && n < 8) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("cycles", n[7:0], 8'h03);
            chk("ready", {7'h00, rdy}, 8'h01);
        end
    endtask
    task automatic t_reset();
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset w", wr, 8'h00);
        chk("reset z", {7'h00, zf}, 8'h00);
        chk("reset ready", {7'h00, rdy}, 8'h01);
        chk("reset done", {7'h00, done}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_illegal();
        run_op(16'h9000, 1'b1);
        run_op(16'h0c00, 1'b1);
        run_op(16'h8000, 1'b1);
        $display("test illegal done");
    endtask
    task automatic t_and();
        abcd_file_model_inst.mem[8'hff] = 8'hc2;
        abcd_file_model_inst.mem[8'h00] = 8'h17;
        run_op(16'h0aff, 1'b0);
        chk("w", wr, 8'h00);
        chk("z", {7'h00, zf}, 8'h01);
        chk("no write", {7'h00, fwr}, 8'h00);
        run_op(16'h0b00, 1'b0);
        chk("write", {7'h00, fwr}, 8'h01);
        chk("wdata", fwd, 8'h00);
        $display("test and done");
    endtask
    task automatic t_clr();
        logic [7:0] a;
        for (int b = 0; b < 8; b++) begin
            a = {b[2:0], b[2:0], 2'h3};
            abcd_file_model_inst.mem[a] = 8'hff;
            run_op({5'h11, b[2:0], a}, 1'b0);
            chk("addr", fa, a);
            chk("wdata", fwd, ~(8'h01 << b));
            chk("write", {7'h00, fwr}, 8'h01);
            chk("z", {7'h00, zf}, 8'h01);
        end
        $display("test clear done");
    endtask
    initial begin
        t_reset();
        t_and();
        t_clr();
        t_illegal();
        tally_and_finish();
    end
endmodule
`default_nettype wire
